// >>> pkg/srp_pkg.sv
package srp_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_START1 = 8'h04;
   localparam logic [7:0] ADDR_START2 = 8'h08;
   localparam logic [7:0] ADDR_END1   = 8'h0C;
   localparam logic [7:0] ADDR_END2   = 8'h10;
   localparam logic [7:0] ADDR_LEN    = 8'h14;
   localparam logic [7:0] ADDR_MTU    = 8'h18;
   localparam logic [7:0] ADDR_STAT   = 8'h1C;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int          SEQ_SIZE_LSB   = 24;
   localparam int          ADD_LSB        = 16;
   localparam logic [1:0]  MODE_NONE      = 2'h0;
   localparam logic [1:0]  MODE_STARTEND  = 2'h1;
   localparam logic [1:0]  MODE_LENFIELD  = 2'h2;
   localparam logic [10:0] MTU_DEFAULT    = 11'h230;
   localparam logic [10:0] MTU_MAX        = 11'h400;
   localparam logic [1:0]  SEQ_MAX        = 2'h3;

   // Pattern register: up to three bytes plus a size
   typedef struct packed {
      logic [1:0]  size;
      logic [23:0] bytes;
   } srp_seq_type;

   // Byte travelling to the network side
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } srp_beat_type;

   // Receive states
   typedef enum logic [3:0] {
      ST_HUNT = 4'h1,
      ST_BODY = 4'h2,
      ST_TAIL = 4'h4,
      ST_PASS = 4'h8
   } srp_state_type;

endpackage

// >>> verilog/srp_fifo.sv
module srp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rstn_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   // Pointer wrap bit only works for power-of-two depths
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("srp_fifo: DEPTH must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire              empty = (wr_ptr == rd_ptr);
   wire              push  = in_valid_i && !full;
   wire              pop   = out_ready_i && !empty;

   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   // Pointers; a push into a full store is refused by in_ready_o
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage carries no reset
   always_ff @(posedge clock_i) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
   end

endmodule // srp_fifo

// >>> verilog/srp_packetizer.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
module srp_packetizer #(
   parameter int FIFO_DEPTH = 32
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Serial receive bytes
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             rx_ready_o,
   // Network side
   output logic             net_valid_o,
   output logic      [7:0]  net_data_o,
   output logic             net_last_o,
   input  wire logic        net_ready_i
);

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("srp_packetizer: FIFO_DEPTH too small");
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0]         ctrl;  // [1:0] mode, [2] fifo on, [3] lsb first
   srp_pkg::srp_seq_type start1, start2, end1, end2;
   logic [31:0]         lenreg; // [15:0] offset, [17:16] width, [31:24] extra
   logic [10:0]         mtu;
   logic [15:0]         drop_cnt;
   logic [15:0]         gram_cnt;

   wire [1:0]  mode     = ctrl[1:0];
   wire        fifo_on  = ctrl[2];
   wire        lsb_1st  = ctrl[3];
   wire [7:0]  trail    = ctrl[23:16];
   wire [15:0] len_off  = lenreg[15:0];
   wire [1:0]  len_wid  = lenreg[17:16];
   wire [7:0]  len_add  = lenreg[31:24];

   wire acc     = psel_i && penable_i;
   wire wr_en   = acc && pwrite_i;
   wire addr_ok = (paddr_i <= srp_pkg::ADDR_STAT) && (paddr_i[1:0] == 2'h0);

   // Read decode
   logic [31:0] rd_mux;
   always_comb begin
      unique case (paddr_i)
         srp_pkg::ADDR_CTRL:   rd_mux = ctrl;
         srp_pkg::ADDR_START1: rd_mux = {6'h00, start1};
         srp_pkg::ADDR_START2: rd_mux = {6'h00, start2};
         srp_pkg::ADDR_END1:   rd_mux = {6'h00, end1};
         srp_pkg::ADDR_END2:   rd_mux = {6'h00, end2};
         srp_pkg::ADDR_LEN:    rd_mux = lenreg;
         srp_pkg::ADDR_MTU:    rd_mux = {21'h000000, mtu};
         srp_pkg::ADDR_STAT:   rd_mux = {gram_cnt, drop_cnt};
         default:              rd_mux = 32'h00000000;
      endcase
   end

   // Bus answer: one access cycle, error on unmapped address
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !addr_ok;
         prdata_o  <= rd_mux;
      end
   end

   // Register writes take effect at the completing edge
   wire wr_take = wr_en && pready_o && addr_ok;
   wire [10:0] mtu_w = (pwdata_i[10:0] > srp_pkg::MTU_MAX) ? srp_pkg::MTU_MAX : pwdata_i[10:0];
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ctrl   <= 32'h00000000;
         start1 <= '0;
         start2 <= '0;
         end1   <= '0;
         end2   <= '0;
         lenreg <= 32'h00000000;
         mtu    <= srp_pkg::MTU_DEFAULT;
      end else if (wr_take) begin
         unique case (paddr_i)
            srp_pkg::ADDR_CTRL:   ctrl   <= pwdata_i;
            srp_pkg::ADDR_START1: start1 <= pwdata_i[25:0];
            srp_pkg::ADDR_START2: start2 <= pwdata_i[25:0];
            srp_pkg::ADDR_END1:   end1   <= pwdata_i[25:0];
            srp_pkg::ADDR_END2:   end2   <= pwdata_i[25:0];
            srp_pkg::ADDR_LEN:    lenreg <= pwdata_i;
            srp_pkg::ADDR_MTU:    mtu    <= (mtu_w == 11'h000) ? srp_pkg::MTU_DEFAULT : mtu_w;
            default:              ;
         endcase
      end
   end

   // ----------------------------------------
   // Receive path, optional FIFO
   // ----------------------------------------
   logic       f_valid, f_ready, f_in_ready;
   logic [7:0] f_data;
   logic       core_take;
   wire        byp_valid = fifo_on ? f_valid : rx_valid_i;
   wire [7:0]  byp_data  = fifo_on ? f_data  : rx_data_i;
   assign f_ready    = fifo_on && core_take;
   assign rx_ready_o = fifo_on ? f_in_ready : core_take;

   srp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) srp_fifo_i (
      .clock_i     (clock_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (rx_valid_i && fifo_on),
      .in_ready_o  (f_in_ready),
      .in_data_i   (rx_data_i),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready),
      .out_data_o  (f_data)
   );

   // ----------------------------------------
   // Framing engine
   // ----------------------------------------
   srp_pkg::srp_state_type held_state, state, next_state;
   logic [23:0] hist;     // last three bytes, newest low
   logic [10:0] count;    // bytes in current datagram
   logic [7:0]  tail_cnt;
   logic [15:0] len_val;
   logic        out_full; // output register holds a beat

   // Output stage is a single beat; engine stalls while it is held
   assign core_take = byp_valid && (!out_full || net_ready_i);

   // Mode writes act on the next byte, so no stale pass byte leaks into a frame
   assign state = srp_pkg::srp_state_type'((mode == srp_pkg::MODE_NONE) ? srp_pkg::ST_PASS :
                  (held_state == srp_pkg::ST_PASS) ? srp_pkg::ST_HUNT : held_state);

   wire [23:0] hist_n = {hist[15:0], byp_data};

   function automatic logic seq_hit(input srp_pkg::srp_seq_type s, input logic [23:0] h);
      logic [23:0] m;
      m = 24'h000000;
      unique case (s.size)
         2'h1:    m = 24'h0000FF;
         2'h2:    m = 24'h00FFFF;
         2'h3:    m = 24'hFFFFFF;
         default: m = 24'h000000;
      endcase
      seq_hit = (s.size != 2'h0) && ((h & m) == (s.bytes & m));
   endfunction

   // start sizes zero mean end alone (start/end mode only)
   wire start_on   = (start1.size != 2'h0) || ((mode == srp_pkg::MODE_STARTEND) && (start2.size != 2'h0));
   wire start_hit  = seq_hit(start1, hist_n) || ((mode == srp_pkg::MODE_STARTEND) && seq_hit(start2, hist_n));
   wire end_hit    = seq_hit(end1, hist_n) || seq_hit(end2, hist_n);
   wire [1:0] s_sz = seq_hit(start1, hist_n) ? start1.size : start2.size;

   // field byte index from datagram start
   wire [15:0] idx     = {5'h00, count};
   wire        in_fld  = (idx >= len_off) && (idx < len_off + {14'h0000, len_wid});
   wire [1:0]  fld_pos = 2'(idx - len_off);
   wire [15:0] len_n   = !in_fld ? len_val :
                         lsb_1st ? (len_val | (16'(byp_data) << {fld_pos, 3'h0})) :
                                   {len_val[7:0], byp_data};
   wire        len_done = (idx >= len_off + {14'h0000, len_wid}) &&
                          ({5'h00, count} + 16'h0001 == len_n + {8'h00, len_add});
   wire        mtu_hit  = (count + 11'h001 >= mtu);

   // Decide next state and whether this byte closes a datagram
   logic last_b, keep_b;
   always_comb begin
      next_state = state;
      last_b     = 1'b0;
      keep_b     = 1'b1;
      unique case (state)
         srp_pkg::ST_PASS: begin
            last_b = 1'b1;
            if (mode != srp_pkg::MODE_NONE) next_state = srp_pkg::ST_HUNT;
         end
         srp_pkg::ST_HUNT: begin
            keep_b = start_hit || (mode == srp_pkg::MODE_STARTEND && !start_on);
            if (mode == srp_pkg::MODE_NONE) next_state = srp_pkg::ST_PASS;
            else if (keep_b) next_state = srp_pkg::ST_BODY;
         end
         srp_pkg::ST_BODY: begin
            if (mode == srp_pkg::MODE_STARTEND && end_hit) begin
               if (trail == 8'h00) last_b = 1'b1;
               else next_state = srp_pkg::ST_TAIL;
            end
            // length framing ends on field value
            if (mode == srp_pkg::MODE_LENFIELD && len_done) last_b = 1'b1;
         end
         srp_pkg::ST_TAIL: begin
            if (tail_cnt + 8'h01 >= trail) last_b = 1'b1;
         end
         default: next_state = srp_pkg::ST_HUNT;
      endcase
      if (state != srp_pkg::ST_PASS && keep_b && mtu_hit) last_b = 1'b1;
      if (last_b && state != srp_pkg::ST_PASS) next_state = srp_pkg::ST_HUNT;
   end

   wire [10:0] count_start = (state == srp_pkg::ST_HUNT && start_hit) ? {9'h000, s_sz} : 11'h001;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         held_state <= srp_pkg::ST_PASS;
         hist     <= 24'h000000;
         count    <= 11'h000;
         tail_cnt <= 8'h00;
         len_val  <= 16'h0000;
         drop_cnt <= 16'h0000;
         gram_cnt <= 16'h0000;
      end else if (core_take) begin
         held_state <= next_state;
         hist     <= (last_b || !keep_b) ? 24'h000000 : hist_n;
         count    <= last_b ? 11'h000 : (state == srp_pkg::ST_HUNT ? count_start : count + 11'h001);
         tail_cnt <= (state == srp_pkg::ST_TAIL && !last_b) ? tail_cnt + 8'h01 : 8'h00;
         len_val  <= (last_b || state == srp_pkg::ST_HUNT) ? 16'h0000 : len_n;
         if (!keep_b) drop_cnt <= drop_cnt + 16'h0001;
         if (last_b)  gram_cnt <= gram_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         out_full    <= 1'b0;
         net_valid_o <= 1'b0;
         net_data_o  <= 8'h00;
         net_last_o  <= 1'b0;
      end else if (core_take && keep_b) begin
         out_full    <= 1'b1;
         net_valid_o <= 1'b1;
         net_data_o  <= byp_data;
         net_last_o  <= last_b;
      end else if (net_ready_i) begin
         out_full    <= 1'b0;
         net_valid_o <= 1'b0;
         net_last_o  <= 1'b0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_MTU_FLUSH: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && keep_b && state != srp_pkg::ST_PASS && mtu_hit |=> net_last_o)
      else $error("limit reached without last flag");
   AST_PASS_LAST: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && state == srp_pkg::ST_PASS |=> net_valid_o && net_last_o && net_data_o == $past(byp_data))
      else $error("pass mode byte not forwarded");
   AST_END_CLOSE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && state == srp_pkg::ST_BODY && mode == srp_pkg::MODE_STARTEND && end_hit && trail == 8'h00
      |=> net_last_o && state == srp_pkg::ST_HUNT)
      else $error("end pattern did not close datagram");
   AST_TAIL_GO: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && state == srp_pkg::ST_BODY && mode == srp_pkg::MODE_STARTEND && end_hit && trail != 8'h00
      && !mtu_hit |=> state == srp_pkg::ST_TAIL && !net_last_o)
      else $error("trailer not collected");
   AST_HUNT_DROP: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && state == srp_pkg::ST_HUNT && start_on && !start_hit |=> !net_valid_o)
      else $error("unframed byte forwarded");
   AST_START_CNT: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && state == srp_pkg::ST_HUNT && start_hit && !last_b |=> count == {9'h000, $past(s_sz)})
      else $error("count not seeded by start match");
   AST_LEN_END: assert property (@(posedge clock_i) disable iff (!rstn_i)
      core_take && state == srp_pkg::ST_BODY && mode == srp_pkg::MODE_LENFIELD && len_done |=> net_last_o)
      else $error("length datagram not released");
   AST_BYPASS: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !fifo_on && rx_valid_i && rx_ready_o && state == srp_pkg::ST_PASS
      |=> net_valid_o && net_data_o == $past(rx_data_i))
      else $error("bypass byte not forwarded next cycle");

endmodule // srp_packetizer

// >>> dv/srp_serial_model.sv
// ----------------------------------------
// Serial terminal side of the packetizer
// ----------------------------------------
module srp_serial_model (
   // Clock
   input  wire logic       clock_i,
   // Byte handshake
   input  wire logic       rx_ready_i,
   output logic            rx_valid_o,
   output logic      [7:0] rx_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int sent = 0;

   // Idle line at time zero
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
   end

   // Send bytes in order, gap cycles idle between them
   // stimulus never carries mode characters
   task automatic send(input logic [7:0] tx[$], input int gap);
      foreach (tx[i]) begin
         rx_valid_o <= 1'b1;
         rx_data_o  <= tx[i];
         do @(posedge clock_i); while (rx_ready_i !== 1'b1);
         sent++;
         if (gap > 0) begin
            rx_valid_o <= 1'b0;
            rx_data_o  <= ~tx[i];   // No stale byte while idle
            repeat (gap) @(posedge clock_i);
         end
      end
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~tx[tx.size()-1];
   endtask
endmodule // srp_serial_model

// >>> dv/test_srp_packetizer.sv
module test_srp_packetizer;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Signals and bench state
   // ----------------------------------------
   logic                  clock_i   = 1'b0;
   logic                  rstn_i    = 1'b0;
   logic                  psel      = 1'b0;
   logic                  penable   = 1'b0;
   logic                  pwrite    = 1'b0;
   logic [7:0]            paddr     = 8'h00;
   logic [31:0]           pwdata    = 32'h0;
   logic                  net_ready = 1'b0;
   logic                  hold      = 1'b0;
   logic [1:0]            pace      = 2'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  rx_valid;
   logic                  rx_ready;
   logic                  net_valid;
   logic                  net_last;
   logic [7:0]            rx_data;
   logic [7:0]            net_data;
   int                    errors       = 0;
   int                    total_checks = 0;
   srp_pkg::srp_beat_type got[$];

   always #2.5 clock_i = ~clock_i;

   srp_packetizer #(.FIFO_DEPTH(32)) srp_packetizer_i (
      .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready), .net_valid_o(net_valid),
      .net_data_o(net_data), .net_last_o(net_last), .net_ready_i(net_ready));

   srp_serial_model srp_serial_model_i (
      .clock_i(clock_i), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));

   // Network sink; pacing stalls half the time so held beats get exercised
   always @(posedge clock_i) begin
      pace      <= pace + 2'h1;
      net_ready <= ~hold & ~pace[1];
      if (net_valid === 1'b1 && net_ready === 1'b1)
         got.push_back(srp_pkg::srp_beat_type'({net_last, net_data}));
   end

   // ----------------------------------------
   // Compare, bus and stream tasks
   // ----------------------------------------
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk_beat(input string name, input srp_pkg::srp_beat_type exp, input srp_pkg::srp_beat_type seen);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; an edge passes after release so calls never collide
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, addr, wd, rd, err);
   endtask

   task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, addr, 32'h0, rd, err);
      chk_word(name, exp, rd);
      chk_word({name, " error"}, {31'h0, experr}, {31'h0, err});
   endtask

   // Send bytes, expect all but the first skip ones, last flag on the final
   task automatic run(input logic [7:0] tx[$], input int skip, input logic all_last, input int gap);
      int n;
      int cnt;
      n = tx.size() - skip;
      got.delete();
      srp_serial_model_i.send(tx, gap);
      cnt = 0;
      while (got.size() < n && cnt < 600) begin
         @(posedge clock_i);
         cnt++;
      end
      repeat (10) @(posedge clock_i);   // Catch stray extra beats
      chk_word("beat count", 32'(n), 32'(got.size()));
      for (int i = 0; i < n && i < got.size(); i++)
         chk_beat("net beat", srp_pkg::srp_beat_type'({all_last | (i == n - 1), tx[skip+i]}), got[i]);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rdchk("ctrl", srp_pkg::ADDR_CTRL, 32'h0, 1'b0);         // No framing
      rdchk("mtu", srp_pkg::ADDR_MTU, 32'h230, 1'b0);         // Default limit
      wr(srp_pkg::ADDR_MTU, 32'h7FF);
      rdchk("mtu cap", srp_pkg::ADDR_MTU, 32'h400, 1'b0);     // Capped limit
      wr(srp_pkg::ADDR_MTU, 32'h0);
      rdchk("mtu zero", srp_pkg::ADDR_MTU, 32'h230, 1'b0);    // Zero falls back
      rdchk("unmapped", 8'h20, 32'h0, 1'b1);
   endtask

   task automatic t_startend();
      wr(srp_pkg::ADDR_START1, 32'h0100003A);
      wr(srp_pkg::ADDR_START2, 32'h0);
      wr(srp_pkg::ADDR_END1, 32'h02000D0A);
      wr(srp_pkg::ADDR_END2, 32'h01000003);
      wr(srp_pkg::ADDR_CTRL, 32'h1);
      run('{8'h55, 8'h3A, 8'h41, 8'h0D, 8'h0A}, 1, 1'b0, 0);   // Start then end
      wr(srp_pkg::ADDR_CTRL, 32'h00020001);
      run('{8'h3A, 8'h42, 8'h03, 8'h11, 8'h22}, 0, 1'b0, 2);   // Second end, trailer
      wr(srp_pkg::ADDR_START1, 32'h0);
      wr(srp_pkg::ADDR_CTRL, 32'h1);
      run('{8'h61, 8'h0D, 8'h0A}, 0, 1'b0, 0);                 // End pattern alone
   endtask

   task automatic t_len();
      wr(srp_pkg::ADDR_START1, 32'h01000002);
      wr(srp_pkg::ADDR_LEN, 32'h00020001);
      wr(srp_pkg::ADDR_CTRL, 32'h2);
      run('{8'h77, 8'h02, 8'h00, 8'h05, 8'hAA, 8'hBB}, 1, 1'b0, 0); // High byte first
      wr(srp_pkg::ADDR_LEN, 32'h01020001);
      wr(srp_pkg::ADDR_CTRL, 32'hA);
      run('{8'h02, 8'h04, 8'h00, 8'hCC, 8'hDD}, 0, 1'b0, 1);   // Low byte first, correction
   endtask

   task automatic t_mtu();
      wr(srp_pkg::ADDR_START1, 32'h0100003A);
      wr(srp_pkg::ADDR_MTU, 32'h4);
      wr(srp_pkg::ADDR_CTRL, 32'h1);
      run('{8'h3A, 8'h01, 8'h02, 8'h04}, 0, 1'b0, 0);          // Flush at limit
      wr(srp_pkg::ADDR_START2, 32'h01000024);
      run('{8'h24, 8'h0D, 8'h0A}, 0, 1'b0, 0);                 // Second start pattern
   endtask

   // Fill the buffer with the sink stalled, then drain it
   task automatic t_fifo();
      logic [7:0] tx[$];
      int         base;
      for (int i = 0; i < 40; i++)
         tx.push_back(8'(8'h40 + i));
      wr(srp_pkg::ADDR_CTRL, 32'h4);
      base = srp_serial_model_i.sent;
      hold <= 1'b1;
      fork
         run(tx, 0, 1'b1, 0);                                   // Each byte alone, held back until the sink resumes
      join_none
      repeat (150) @(posedge clock_i);
      chk_word("rx ready full", 32'h0, {31'h0, rx_ready});      // Full buffer refuses
      base = srp_serial_model_i.sent - base;
      chk_word("buffered", 32'h1, {31'h0, base >= 32 && base < 40});
      hold <= 1'b0;
      wait fork;
   endtask

   // ----------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------
   task automatic test_done();
      $display("Checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      t_regs();
      run('{8'h11, 8'h22, 8'h33}, 0, 1'b1, 0);                 // Each byte alone
      t_startend();
      t_len();
      t_mtu();
      t_fifo();
      rdchk("stat", srp_pkg::ADDR_STAT, 32'h00320002, 1'b0);  // Two dropped, fifty closed
      test_done();
   end

   // Whole run needs well under a thousand cycles; this bound is generous
   initial begin
      repeat (20000) @(posedge clock_i);
      errors++;
      test_done();
   end
endmodule // test_srp_packetizer
